// [include/dcsi_pkg.sv]
`default_nettype none

// Shared constants and carriers for the DC sensor interface control
package dcsi_pkg;

  // Widths
  localparam int NUM_CH = 4;                   // Sensor channels
  localparam int CH_W   = 2;                   // Channel index width
  localparam int ADDR_W = 8;                   // Register address width
  localparam int DATA_W = 32;                  // Register data width
  localparam int RES_W  = 10;                  // Conversion result width
  localparam int CODE_W = 6;                   // Conversion request code width

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SWITCH = 8'h00;  // sensor_switch_control
  localparam logic [ADDR_W-1:0] OFF_SYSCFG = 8'h04;  // system_config
  localparam logic [ADDR_W-1:0] OFF_DIAG   = 8'h08;  // diag_convert_control
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h0c;  // conversion_result
  localparam logic [ADDR_W-1:0] OFF_PINS   = 8'h10;  // Pin state view

  // Field positions
  localparam int SW_SRC_BIT  = 0;              // output_source_enable
  localparam int SW_CHAN_LSB = 1;              // channel_select
  localparam int SW_PDDIS_BIT = 3;             // pulldown_global_disable
  localparam int CFG_AUTO_BIT = 0;             // auto_off_after_measure
  localparam int DG_CODE_LSB = 0;              // conversion_request_code
  localparam int DG_CHAN_LSB = 8;              // Measured channel
  localparam int DG_BUSY_BIT = 12;             // Conversion in progress
  localparam int RS_VAL_LSB  = 0;              // Result value
  localparam int RS_DONE_BIT = 16;             // Result ready flag
  localparam int RS_REF_BIT  = 17;             // Refused request flag
  localparam int PN_SRC_LSB  = 0;              // Source per channel
  localparam int PN_PD_LSB   = 4;              // Pull-down per channel
  localparam int PN_RI_LSB   = 8;              // Current route per channel
  localparam int PN_RV_LSB   = 12;             // Voltage route per channel

  // Conversion request codes
  localparam logic [CODE_W-1:0] REQ_CURRENT = 6'h04;
  localparam logic [CODE_W-1:0] REQ_VOLTAGE = 6'h03;

  // Reset values
  localparam logic RST_PULLDOWN = 1'b1;        // Pull-downs on after reset
  localparam logic [NUM_CH-1:0] CH_ONE = 4'h1; // One-hot seed

  // Conversion sequencer states
  typedef enum logic [0:0] {
    DCSI_IDLE = 1'b0,
    DCSI_CONV = 1'b1
  } dcsi_fsm_t;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } dcsi_bus_req_t;

  // Request toward the shared ADC and its input routing
  typedef struct packed {
    logic              req;
    logic [CODE_W-1:0] code;
    logic [CH_W-1:0]   chan;
    logic [NUM_CH-1:0] route_i;
    logic [NUM_CH-1:0] route_v;
  } dcsi_adc_req_t;

  // Answer from the ADC
  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] result;
  } dcsi_adc_rsp_t;

endpackage

`default_nettype wire

// [core/dcsi_pulldown_cell.sv]
`default_nettype none

// One channel's weak pull-down control
module dcsi_pulldown_cell
  import dcsi_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic src_on_in,
  input  wire logic volt_req_in,
  input  wire logic gdis_in,
  output var  logic pd_en_out
);

  // Cell state
  typedef struct packed {
    logic pd_en;                 // Pull-down engaged
  } dcsi_pd_state_t;

  dcsi_pd_state_t s_r;           // Registered state
  dcsi_pd_state_t s_nxt;         // Next state

  // Release on any condition, re-engage once none holds
  always_comb begin
    s_nxt = s_r;
    if (src_on_in) begin
      s_nxt.pd_en = 1'b0;
    end else if (volt_req_in) begin
      s_nxt.pd_en = 1'b0;
    end else if (gdis_in) begin
      s_nxt.pd_en = 1'b0;
    end else begin
      s_nxt.pd_en = 1'b1;
    end
  end

  // State register, engaged out of reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r.pd_en <= RST_PULLDOWN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pd_en_out = s_r.pd_en;

endmodule

`default_nettype wire

// [core/dcsi_ctrl.sv]
//
// Contract
// - Source drives pins only while enabled
// - Source goes to selected channel only
// - Channels change only by host command
// - Auto-off after measurement when configured; here only when the measured channel is the selected source channel
// - ADC routing only on requested conversion
// - All pull-downs engaged after reset
// - Active source releases own pull-down
// - Voltage request releases channel pull-down
// - Global disable releases all pull-downs
// - Hall sensor: single current conversion
// - Resistive: current then voltage conversion
// - Current code 04, voltage code 03
// - Cross-link: source one, measure another
//
// The address map and the address-and-strobe port were left to the implementer.

`default_nettype none

module dcsi_ctrl
  import dcsi_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire dcsi_bus_req_t     bus_in,
  output var  logic [DATA_W-1:0] rdata_out,
  input  wire dcsi_adc_rsp_t     adc_in,
  output var  dcsi_adc_req_t     adc_out,
  output var  logic [NUM_CH-1:0] src_on_out,
  output var  logic [NUM_CH-1:0] pulldown_out
);

  // Whole block state
  typedef struct packed {
    logic              src_en;     // Output source enable
    logic [CH_W-1:0]   chan_sel;   // Source channel
    logic              pd_gdis;    // Global pull-down disable
    logic              auto_off;   // Switch off after measurement
    dcsi_fsm_t         fsm;        // Conversion sequencer
    logic [RES_W-1:0]  result;     // Last conversion value
    logic              done;       // Result ready, sticky
    logic              refused;    // Request refused, sticky
    dcsi_adc_req_t     adc;        // ADC request and routing
    logic [NUM_CH-1:0] src_on;     // Per-channel source drive
    logic [DATA_W-1:0] rdata;      // Read data for one cycle
  } dcsi_state_t;

  dcsi_state_t s_r;                // Registered state
  dcsi_state_t s_nxt;              // Next state

  logic rst_meta_r;                // Reset release, first stage
  logic rst_sync_r;                // Reset release, second stage

  logic [NUM_CH-1:0] pd_en;        // Pull-down cell outputs

  // Decoded write strobes
  logic wr_switch;                 // Write to switch control
  logic wr_syscfg;                 // Write to configuration
  logic wr_diag;                   // Write to conversion control
  logic wr_result;                 // Write to result flags

  // Write data fields
  logic [CODE_W-1:0] w_code;       // Requested code
  logic [CH_W-1:0]   w_chan;       // Requested channel
  logic              code_ok;      // Code is supported
  logic              accept;       // Request taken

  // Reset release through two flip-flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Address decode of writes
  always_comb begin
    wr_switch = bus_in.wr && (bus_in.addr == OFF_SWITCH);
    wr_syscfg = bus_in.wr && (bus_in.addr == OFF_SYSCFG);
    wr_diag   = bus_in.wr && (bus_in.addr == OFF_DIAG);
    wr_result = bus_in.wr && (bus_in.addr == OFF_RESULT);
  end

  // Conversion request fields and acceptance
  always_comb begin
    w_code  = bus_in.wdata[DG_CODE_LSB +: CODE_W];
    w_chan  = bus_in.wdata[DG_CHAN_LSB +: CH_W];
    // Only current and voltage codes are served
    code_ok = (w_code == REQ_CURRENT) || (w_code == REQ_VOLTAGE);
    // One conversion at a time
    accept  = wr_diag && code_ok && (s_r.fsm == DCSI_IDLE);
  end

  // Next-state logic
  always_comb begin
    s_nxt       = s_r;
    // Read data is zero outside the answer cycle
    s_nxt.rdata = '0;

    // Configuration register
    if (wr_syscfg) begin
      s_nxt.auto_off = bus_in.wdata[CFG_AUTO_BIT];
    end

    // Host flag clears, one per bit
    if (wr_result) begin
      if (bus_in.wdata[RS_DONE_BIT]) begin
        s_nxt.done = 1'b0;
      end
      if (bus_in.wdata[RS_REF_BIT]) begin
        s_nxt.refused = 1'b0;
      end
    end

    // Conversion sequencer
    case (s_r.fsm)
      DCSI_IDLE: begin
        if (accept) begin
          // Start one conversion toward the ADC
          s_nxt.fsm      = DCSI_CONV;
          s_nxt.adc.req  = 1'b1;
          s_nxt.adc.code = w_code;
          s_nxt.adc.chan = w_chan;
        end
      end
      DCSI_CONV: begin
        if (adc_in.done) begin
          // Capture value, set wins over a clear
          s_nxt.fsm     = DCSI_IDLE;
          s_nxt.adc.req = 1'b0;
          s_nxt.result  = adc_in.result;
          s_nxt.done    = 1'b1;
          // Measurement done on the sourced channel
          if (s_r.auto_off && (s_r.adc.chan == s_r.chan_sel)) begin
            s_nxt.src_en = 1'b0;
          end
        end
      end
      default: begin
        // Recover to idle
        s_nxt.fsm     = DCSI_IDLE;
        s_nxt.adc.req = 1'b0;
      end
    endcase

    // Refused request: busy or unknown code
    if (wr_diag && !accept) begin
      s_nxt.refused = 1'b1;
    end

    // Host switch command, latest word wins
    if (wr_switch) begin
      s_nxt.src_en   = bus_in.wdata[SW_SRC_BIT];
      s_nxt.chan_sel = bus_in.wdata[SW_CHAN_LSB +: CH_W];
      s_nxt.pd_gdis  = bus_in.wdata[SW_PDDIS_BIT];
    end

    // Source drive: one channel, only while enabled
    if (s_nxt.src_en) begin
      s_nxt.src_on = CH_ONE << s_nxt.chan_sel;
    end else begin
      s_nxt.src_on = '0;
    end

    // Current routing while a current conversion runs
    if (s_nxt.fsm == DCSI_CONV && s_nxt.adc.code == REQ_CURRENT) begin
      s_nxt.adc.route_i = CH_ONE << s_nxt.adc.chan;
    end else begin
      s_nxt.adc.route_i = '0;
    end

    // Voltage routing, any channel, even unsourced
    if (s_nxt.fsm == DCSI_CONV && s_nxt.adc.code == REQ_VOLTAGE) begin
      s_nxt.adc.route_v = CH_ONE << s_nxt.adc.chan;
    end else begin
      s_nxt.adc.route_v = '0;
    end

    // Register reads, answered next cycle
    if (bus_in.rd) begin
      case (bus_in.addr)
        OFF_SWITCH: begin
          // Switch control readback
          s_nxt.rdata[SW_SRC_BIT]               = s_r.src_en;
          s_nxt.rdata[SW_CHAN_LSB +: CH_W]      = s_r.chan_sel;
          s_nxt.rdata[SW_PDDIS_BIT]             = s_r.pd_gdis;
        end
        OFF_SYSCFG: begin
          // Configuration readback
          s_nxt.rdata[CFG_AUTO_BIT]             = s_r.auto_off;
        end
        OFF_DIAG: begin
          // Last request and busy
          s_nxt.rdata[DG_CODE_LSB +: CODE_W]    = s_r.adc.code;
          s_nxt.rdata[DG_CHAN_LSB +: CH_W]      = s_r.adc.chan;
          s_nxt.rdata[DG_BUSY_BIT]              = (s_r.fsm == DCSI_CONV);
        end
        OFF_RESULT: begin
          // Value and sticky flags
          s_nxt.rdata[RS_VAL_LSB +: RES_W]      = s_r.result;
          s_nxt.rdata[RS_DONE_BIT]              = s_r.done;
          s_nxt.rdata[RS_REF_BIT]               = s_r.refused;
        end
        OFF_PINS: begin
          // Live drive, pull-down and routing state
          s_nxt.rdata[PN_SRC_LSB +: NUM_CH]     = s_r.src_on;
          s_nxt.rdata[PN_PD_LSB +: NUM_CH]      = pd_en;
          s_nxt.rdata[PN_RI_LSB +: NUM_CH]      = s_r.adc.route_i;
          s_nxt.rdata[PN_RV_LSB +: NUM_CH]      = s_r.adc.route_v;
        end
        default: begin
          // Unmapped address reads zero
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      // Sources off, idle, nothing routed
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Per-channel pull-down cells
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_pd
      dcsi_pulldown_cell u_pd (
        .clk_in      (clk_in),
        .rst_n_in    (rst_sync_r),
        .src_on_in   (s_r.src_on[ch]),
        .volt_req_in (s_r.adc.route_v[ch]),
        .gdis_in     (s_r.pd_gdis),
        .pd_en_out   (pd_en[ch])
      );
    end
  endgenerate

  // Outputs straight from flip-flops
  assign rdata_out    = s_r.rdata;
  assign adc_out      = s_r.adc;
  assign src_on_out   = s_r.src_on;
  assign pulldown_out = pd_en;

endmodule

`default_nettype wire

// [test/dcsi_ctrl_properties.sv]
`default_nettype none

// Port-level checks of the sensor interface control
module dcsi_ctrl_properties
  import dcsi_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              reset_n_in,
  input wire dcsi_bus_req_t     bus_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire dcsi_adc_rsp_t     adc_in,
  input wire dcsi_adc_req_t     adc_out,
  input wire logic [NUM_CH-1:0] src_on_out,
  input wire logic [NUM_CH-1:0] pulldown_out
);
  // All checks on the rising edge, idle while reset is low
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Switch register write
  wire logic sw_wr = bus_in.wr && bus_in.addr == OFF_SWITCH;
  // Conversion request that the block must accept
  wire logic dg_ok = bus_in.wr && bus_in.addr == OFF_DIAG && !adc_out.req &&
    (bus_in.wdata[5:0] == REQ_CURRENT || bus_in.wdata[5:0] == REQ_VOLTAGE);
  // Steps of one conversion
  sequence s_start;
    dg_ok;
  endsequence
  sequence s_done;
    adc_out.req && adc_in.done;
  endsequence
  property p_src_one;
    $onehot0(src_on_out);
  endproperty
  property p_src_wr;
    sw_wr |=> src_on_out == ($past(bus_in.wdata[SW_SRC_BIT]) ?
      CH_ONE << $past(bus_in.wdata[2:1]) : 4'h0);
  endproperty
  property p_src_cause;
    $changed(src_on_out) |-> $past(sw_wr) || $past(adc_in.done);
  endproperty
  property p_start;
    s_start |=> adc_out.req && adc_out.code == $past(bus_in.wdata[5:0]) &&
      adc_out.chan == $past(bus_in.wdata[9:8]);
  endproperty
  property p_end;
    s_done |=> !adc_out.req && adc_out.route_i == 4'h0 && adc_out.route_v == 4'h0;
  endproperty
  property p_route;
    (adc_out.route_i | adc_out.route_v) == (adc_out.req ? CH_ONE << adc_out.chan : 4'h0);
  endproperty
  property p_code;
    adc_out.req |-> (adc_out.code == REQ_CURRENT && adc_out.route_v == 4'h0) ||
      (adc_out.code == REQ_VOLTAGE && adc_out.route_i == 4'h0);
  endproperty
  property p_pd_rel;
    (pulldown_out & $past(src_on_out | adc_out.route_v)) == 4'h0;
  endproperty
  property p_rd_idle;
    !$past(bus_in.rd) |-> rdata_out == 32'h0;
  endproperty
  a_src_one: assert property (p_src_one) else $error("two sources");
  a_src_wr: assert property (p_src_wr) else $error("source write");
  a_src_cause: assert property (p_src_cause) else $error("source moved");
  a_start: assert property (p_start) else $error("no start");
  a_end: assert property (p_end) else $error("no end");
  a_route: assert property (p_route) else $error("bad route");
  a_code: assert property (p_code) else $error("bad code");
  a_pd_rel: assert property (p_pd_rel) else $error("pull-down held");
  a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
endmodule

bind dcsi_ctrl dcsi_ctrl_properties i_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .adc_in(adc_in), .adc_out(adc_out),
  .src_on_out(src_on_out), .pulldown_out(pulldown_out));

`default_nettype wire

// [test/dcsi_adc_model.sv]
`default_nettype none

// Shared ADC: answers current quickly and voltage slowly
module dcsi_adc_model
  import dcsi_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire dcsi_adc_req_t req_in,
  output var  dcsi_adc_rsp_t rsp_out
);
  int cnt; // Cycles since request
  // Result toggles outside done so stale data never match
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      rsp_out <= '0;
    end else begin
      rsp_out.done <= 1'b0;
      rsp_out.result <= ~rsp_out.result;
      cnt <= (req_in.req && !rsp_out.done) ? cnt + 1 : 0;
      if (req_in.req && !rsp_out.done && cnt == (req_in.code == REQ_CURRENT ? 3 : 9)) begin
        rsp_out <= '{1'b1, {2'b10, req_in.chan, req_in.code}};
      end
    end
  end
endmodule

`default_nettype wire

// [test/dc_position_sensor_interface_ctrl_tb_top.sv]
`default_nettype none

// Directed bench for the sensor interface control
module dc_position_sensor_interface_ctrl_tb_top
  import dcsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_in = 1'b0;
  logic              reset_n_in = 1'b0;
  dcsi_bus_req_t     bus = '0;
  dcsi_adc_req_t     aq;
  dcsi_adc_rsp_t     ar;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] last;    // Data of the latest read
  logic [NUM_CH-1:0] src;
  logic [NUM_CH-1:0] pd;
  int                n_errors = 0;
  int                compares = 0;
  int                cyc = 0;
  always #5 clk_in = ~clk_in;
  dcsi_ctrl i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus), .rdata_out(rdata),
    .adc_in(ar), .adc_out(aq), .src_on_out(src), .pulldown_out(pd));
  dcsi_adc_model i_adc (.clk_in(clk_in), .rst_n_in(reset_n_in), .req_in(aq), .rsp_out(ar));
  // Report and stop
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One bus cycle; read data land in last
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_in);
    bus <= '0;
    #1 last = rdata;
    @(posedge clk_in);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(n, e, last);
  endtask
  // Pin view word
  function automatic logic [31:0] pins(input logic [3:0] s, p, i, v);
    return {16'h0, v, i, p, s};
  endfunction
  // Start, check routing, wait, check and clear the result
  task automatic conv(input logic [5:0] c, input logic [1:0] ch, input logic [31:0] e);
    int k;
    acc(1'b1, OFF_DIAG, {22'h0, ch, 2'h0, c});
    // Pull-down cells answer one cycle after the routing
    @(posedge clk_in);
    acc(1'b0, OFF_PINS, 32'h0);
    chk("pins", e, last);
    k = 0;
    do begin
      acc(1'b0, OFF_RESULT, 32'h0);
      k++;
    end while (last[RS_DONE_BIT] !== 1'b1 && k < 30);
    chk("result", {15'h0, 1'b1, 6'h0, 2'b10, ch, c}, last);
    acc(1'b1, OFF_RESULT, 32'h0003_0000);
  endtask
  task automatic t_source();
    logic [1:0] ch;
    for (int c = 0; c < 4; c++) begin
      ch = 2'(c);
      acc(1'b1, OFF_SWITCH, {29'h0, ch, 1'b1});
      rdc("pins", OFF_PINS, pins(CH_ONE << ch, ~(CH_ONE << ch), 0, 0));
      acc(1'b1, OFF_SWITCH, {29'h0, ch, 1'b0});
      rdc("pins", OFF_PINS, pins(0, 4'hf, 0, 0));
    end
    acc(1'b1, OFF_SWITCH, 32'h8);
    rdc("pins", OFF_PINS, pins(0, 0, 0, 0));
    acc(1'b1, OFF_SWITCH, 32'h0);
  endtask
  task automatic t_resist();
    acc(1'b1, OFF_SWITCH, 32'h5);
    conv(REQ_CURRENT, 2'd2, pins(4'h4, 4'hb, 4'h4, 0));
    conv(REQ_VOLTAGE, 2'd2, pins(4'h4, 4'hb, 0, 4'h4));
    acc(1'b1, OFF_SWITCH, 32'h4);
    conv(REQ_VOLTAGE, 2'd2, pins(0, 4'hb, 0, 4'h4));
    acc(1'b1, OFF_SWITCH, 32'h1);
    conv(REQ_VOLTAGE, 2'd3, pins(4'h1, 4'h6, 0, 4'h8));
  endtask
  task automatic t_auto();
    acc(1'b1, OFF_SYSCFG, 32'h1);
    acc(1'b1, OFF_SWITCH, 32'h3);
    conv(REQ_CURRENT, 2'd1, pins(4'h2, 4'hd, 4'h2, 0));
    rdc("pins", OFF_PINS, pins(0, 4'hf, 0, 0));
    acc(1'b1, OFF_SYSCFG, 32'h0);
  endtask
  task automatic t_refuse();
    acc(1'b1, OFF_DIAG, 32'h5);
    // Value of the last current conversion stays beside the refused flag
    rdc("result", OFF_RESULT, {14'h0, 1'b1, 1'b0, 6'h0, 2'b10, 2'd1, REQ_CURRENT});
    acc(1'b1, OFF_RESULT, 32'h0003_0000);
    acc(1'b1, 8'h40, 32'h1);
    rdc("unmapped", 8'h40, 32'h0);
    rdc("pins", OFF_PINS, pins(0, 4'hf, 0, 0));
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rdc("pins", OFF_PINS, pins(0, 4'hf, 0, 0));
    t_source();
    t_resist();
    t_auto();
    t_refuse();
    close_out();
  end
endmodule

`default_nettype wire
